// >>> core/irq_pend_regs.svh
// Register offsets, field masks and reset values for the low-bank pending block
`ifndef IRQ_PEND_REGS_SVH
`define IRQ_PEND_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define PEND_FORCE_OFS     8'h00
`define PEND_WITHDRAW_OFS  8'h04
`define EVT_STATUS_OFS     8'h08
`define EVT_CLEAR_OFS      8'h0C
`define EVT_ENABLE_OFS     8'h10

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define PEND_IMPL_MASK     32'h7FFF_C0FF
`define EVT_PEND_RISE_BIT  0
`define EVT_WDRAW_BLK_BIT  1
`define EVT_WIDTH          2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PEND_RST           32'h0000_0000
`define EVT_RST            2'h0

`endif

// >>> core/irq_pend_pkg.sv
// Types shared by the low-bank pending block
`default_nettype none
package irq_pend_pkg;

  // Register select decoded from the bus address
  typedef enum logic [2:0] {
    SEL_NONE     = 3'h0,
    SEL_FORCE    = 3'h1,
    SEL_WITHDRAW = 3'h3,
    SEL_STATUS   = 3'h2,
    SEL_CLEAR    = 3'h6,
    SEL_ENABLE   = 3'h7
  } reg_sel_t;

endpackage : irq_pend_pkg
`default_nettype wire

// >>> core/irq_pend_events.sv
// Sticky event status, enable mask and level interrupt output
`timescale 1ns/100ps
`default_nettype none
`include "irq_pend_regs.svh"

module irq_pend_events #(
  parameter int unsigned N = `EVT_WIDTH
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic [N-1:0] evt_pulse,
  input  wire logic         clr_we,
  input  wire logic         en_we,
  input  wire logic [N-1:0] wdata,
  output logic      [N-1:0] status,
  output logic      [N-1:0] enable,
  output logic              irq
);

  typedef struct packed {
    logic [N-1:0] sts;
    logic [N-1:0] ena;
  } evt_state_t;

  evt_state_t state_q;
  evt_state_t state_d;

  // Elaboration check: at least one event bit is needed
  if (N < 1) begin : g_n_check
    $error("irq_pend_events: N must be at least 1");
  end

  // ----------------------------------------------------------------------------
  // Next state: a new event wins over a clear in the same cycle
  // ----------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (clr_we) begin
      state_d.sts = state_q.sts & ~wdata;
    end
    state_d.sts = state_d.sts | evt_pulse;
    if (en_we) begin
      state_d.ena = wdata;
    end
  end

  // Synchronous active-low reset
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign status = state_q.sts;
  assign enable = state_q.ena;
  assign irq    = |(state_q.sts & state_q.ena);

  evt_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    |evt_pulse |=> ((status & $past(evt_pulse)) == $past(evt_pulse)))
    else $error("event not held in status");

endmodule : irq_pend_events
`default_nettype wire

// >>> core/irq_pend_low_bank.sv
// Low-bank pending flags with force and withdraw registers
// Offsets: force 0x00, withdraw 0x04, event status 0x08, event clear 0x0C, event enable 0x10.
// Flags reset to zero so every power-up starts from a known, quiet state.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "irq_pend_regs.svh"

module irq_pend_low_bank #(
  parameter int unsigned AW = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic [AW-1:0] addr,
  input  wire logic [31:0]   wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [31:0]   rdata,
  input  wire logic [31:0]   irq_req,
  input  wire logic [31:0]   irq_enabled,
  input  wire logic [31:0]   irq_active,
  output logic      [31:0]   pending,
  output logic               irq
);

  typedef struct packed {
    logic [31:0] pend;
    logic [31:0] rdat;
  } bank_state_t;

  bank_state_t state_q;
  bank_state_t state_d;

  logic [31:0]            impl;
  irq_pend_pkg::reg_sel_t sel;
  logic [1:0]             evt_pulse;
  logic [1:0]             evt_status;
  logic [1:0]             evt_enable;
  logic [31:0]            wd_req;
  logic [31:0]            wd_eff;
  logic [31:0]            fc_req;
  logic                   wr_force;
  logic                   wr_withdraw;
  logic                   wr_clear;
  logic                   wr_enable;

  // Elaboration check: the register map needs five address bits
  if (AW < 5) begin : g_aw_check
    $error("irq_pend_low_bank: AW too small for the register map");
  end

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  function automatic irq_pend_pkg::reg_sel_t decode(input logic [AW-1:0] a);
    case (a)
      AW'(`PEND_FORCE_OFS):    decode = irq_pend_pkg::SEL_FORCE;
      AW'(`PEND_WITHDRAW_OFS): decode = irq_pend_pkg::SEL_WITHDRAW;
      AW'(`EVT_STATUS_OFS):    decode = irq_pend_pkg::SEL_STATUS;
      AW'(`EVT_CLEAR_OFS):     decode = irq_pend_pkg::SEL_CLEAR;
      AW'(`EVT_ENABLE_OFS):    decode = irq_pend_pkg::SEL_ENABLE;
      default:                 decode = irq_pend_pkg::SEL_NONE;
    endcase
  endfunction : decode

  // Strobe qualified by a register select; shared by every write path below
  function automatic logic strobe_hit(input logic strb, input irq_pend_pkg::reg_sel_t s,
                                      input irq_pend_pkg::reg_sel_t want);
    strobe_hit = strb && (s == want);
  endfunction : strobe_hit

  assign sel  = decode(addr);
  assign impl = `PEND_IMPL_MASK; // Bit index equals interrupt number

  // One write strobe per writable register (none for status); wr and rd never overlap on this bus
  assign wr_force    = strobe_hit(wr, sel, irq_pend_pkg::SEL_FORCE);
  assign wr_withdraw = strobe_hit(wr, sel, irq_pend_pkg::SEL_WITHDRAW);
  assign wr_clear    = strobe_hit(wr, sel, irq_pend_pkg::SEL_CLEAR);
  assign wr_enable   = strobe_hit(wr, sel, irq_pend_pkg::SEL_ENABLE);

  // ----------------------------------------------------------------------------
  // Write requests, masked to implemented positions
  // ----------------------------------------------------------------------------
  // Reserved positions are dropped, so a stray one cannot touch anything
  assign wd_req = wr_withdraw ? (wdata & impl) : 32'h0000_0000;
  // In-service interrupts keep their state; zeros clear nothing
  assign wd_eff = wd_req & ~irq_active;
  // Forcing only reaches enabled interrupts, pending or not
  assign fc_req = wr_force ? (wdata & impl & irq_enabled) : 32'h0000_0000;

  // ----------------------------------------------------------------------------
  // Pending flags and read data
  // ----------------------------------------------------------------------------
  // One flag array serves both registers, so a withdraw also drops force readback
  // Hardware requests win over a withdraw in the same cycle so no edge is lost.
  always_comb begin
    state_d      = state_q;
    state_d.pend = ((state_q.pend & ~wd_eff) | fc_req | (irq_req & irq_enabled)) & impl;
    state_d.rdat = 32'h0000_0000;
    if (rd) begin
      case (sel)
        irq_pend_pkg::SEL_FORCE,
        irq_pend_pkg::SEL_WITHDRAW: state_d.rdat = state_q.pend & impl; // Live flags
        irq_pend_pkg::SEL_STATUS:   state_d.rdat = {30'h0000_0000, evt_status};
        irq_pend_pkg::SEL_ENABLE:   state_d.rdat = {30'h0000_0000, evt_enable};
        default:                    state_d.rdat = 32'h0000_0000;
      endcase
    end
  end

  // Flags reset to zero: a defined value is safer than an undefined one
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= '{pend: `PEND_RST, rdat: 32'h0000_0000};
    end else begin
      state_q <= state_d;
    end
  end

  assign pending = state_q.pend;
  assign rdata   = state_q.rdat;

  // ----------------------------------------------------------------------------
  // Events: a flag newly pending, and a withdraw refused by service
  // ----------------------------------------------------------------------------
  assign evt_pulse[`EVT_PEND_RISE_BIT] = |(state_d.pend & ~state_q.pend);
  assign evt_pulse[`EVT_WDRAW_BLK_BIT] = |(wd_req & irq_active);

  irq_pend_events #(
    .N(`EVT_WIDTH)
  ) i_irq_pend_events (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .evt_pulse(evt_pulse),
    .clr_we   (wr_clear),
    .en_we    (wr_enable),
    .wdata    (wdata[1:0]),
    .status   (evt_status),
    .enable   (evt_enable),
    .irq      (irq)
  );

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  sequence withdraw_req_s;
    wr && sel == irq_pend_pkg::SEL_WITHDRAW;
  endsequence

  withdraw_clears_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    withdraw_req_s |=> ((pending & $past(wdata & impl & ~irq_active & ~(irq_req & irq_enabled))) == 32'h0))
    else $error("withdraw did not clear pending flag");

  service_keeps_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    withdraw_req_s |=> ((pending & $past(irq_active & state_q.pend)) == $past(irq_active & state_q.pend)))
    else $error("in-service flag changed by withdraw");

  zero_keeps_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    withdraw_req_s |=> ((pending & $past(~wdata & state_q.pend)) == $past(~wdata & state_q.pend)))
    else $error("zero write altered pending flag");

  read_live_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rd && sel == irq_pend_pkg::SEL_WITHDRAW |=> rdata == $past(pending))
    else $error("withdraw read not live pending");

  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pending & ~impl) == 32'h0)
    else $error("reserved pending bit set");

  shared_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rd && sel == irq_pend_pkg::SEL_FORCE |=> rdata == $past(pending))
    else $error("force and withdraw views differ");

  // Clearing every event with none arriving must drop the level output
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_clear && wdata[1:0] == 2'h3 && evt_pulse == 2'h0 |=> !irq)
    else $error("interrupt output wrong");

  read_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !rd |=> rdata == 32'h0)
    else $error("read data not zero outside read");

  sequence force_req_s;
    wr_force;
  endsequence

  // A force of an enabled line always lands, whatever the line held before
  force_sets_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    force_req_s |=> ((pending & $past(wdata & impl & irq_enabled)) == $past(wdata & impl & irq_enabled)))
    else $error("force did not set pending flag");

  // A disabled line cannot be forced, so a stray one stays harmless
  force_disabled_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    force_req_s |=> ((pending & $past(wdata & impl & ~irq_enabled & ~state_q.pend)) == 32'h0000_0000))
    else $error("disabled line forced pending");

  // Refused withdraws are reported through the event status
  refused_event_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_withdraw && |(wdata & impl & irq_active) |=> evt_status[`EVT_WDRAW_BLK_BIT])
    else $error("refused withdraw not reported");

  // Hardware requests win over a withdraw landing in the same cycle
  hw_request_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    |(irq_req & irq_enabled & impl)
      |=> ((pending & $past(irq_req & irq_enabled & impl)) == $past(irq_req & irq_enabled & impl)))
    else $error("hardware request lost");

  // Unmapped and write-only addresses read as zero
  unmapped_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rd && (sel == irq_pend_pkg::SEL_NONE || sel == irq_pend_pkg::SEL_CLEAR) |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Reset leaves flags, read data and interrupt low; no disable here on purpose
  reset_clear_a: assert property (@(posedge clk_sys)
    !rst_b |=> (pending == 32'h0000_0000 && rdata == 32'h0000_0000 && !irq))
    else $error("state not cleared by reset");

endmodule : irq_pend_low_bank
`default_nettype wire

// >>> sim/irq_pend_low_bank_tb.sv
// Self-checking bench for the low-bank pending block
`timescale 1ns/100ps
`default_nettype none
`include "irq_pend_regs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", n, e, g); end end

module irq_pend_low_bank_tb;
  logic        clk_sys, rst_b, wr, rd, irq, chk_en;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, irq_req, irq_enabled, irq_active, pending;
  logic [31:0] m_pend, m_rd, set_v, clr_v, r;
  logic [1:0]  m_st, m_en, ev_v;
  int          mismatches, tests_run, cyc;
  integer      seed;

  irq_pend_low_bank i_irq_pend_low_bank (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq_req(irq_req), .irq_enabled(irq_enabled),
    .irq_active(irq_active), .pending(pending), .irq(irq));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------------------
  // Reads the inputs the design sampled on this edge; set beats withdraw
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      stop_test();
    end
    set_v = (irq_req | ((wr && addr == `PEND_FORCE_OFS) ? wdata : 32'h0)) & irq_enabled & `PEND_IMPL_MASK;
    clr_v = (wr && addr == `PEND_WITHDRAW_OFS) ? wdata & ~irq_active : 32'h0;
    ev_v  = {wr && addr == `PEND_WITHDRAW_OFS && |(wdata & irq_active & `PEND_IMPL_MASK), |(set_v & ~m_pend)};
    case (rd ? addr : 8'hFF)
      `PEND_FORCE_OFS, `PEND_WITHDRAW_OFS: m_rd <= m_pend;
      `EVT_STATUS_OFS: m_rd <= {30'h0, m_st};
      `EVT_ENABLE_OFS: m_rd <= {30'h0, m_en};
      default: m_rd <= 32'h0;
    endcase
    m_pend <= (m_pend & ~clr_v | set_v) & `PEND_IMPL_MASK;
    m_st   <= m_st & ~((wr && addr == `EVT_CLEAR_OFS) ? wdata[1:0] : 2'h0) | ev_v;
    if (wr && addr == `EVT_ENABLE_OFS) m_en <= wdata[1:0];
    if (!rst_b) begin
      m_pend <= 32'h0;
      m_rd   <= 32'h0;
      m_st   <= 2'h0;
      m_en   <= 2'h0;
    end
  end

  // Outputs are settled half a period after the edge
  always @(negedge clk_sys) if (chk_en) begin
    `CHK("pending", m_pend, pending)
    `CHK("rdata", m_rd, rdata)
    `CHK("irq", |(m_st & m_en), irq)
  end

  // ----------------------------------------------------------------------------
  // Bus tasks and closing
  // ----------------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd   <= 1'b0;
    @(negedge clk_sys);
    `CHK("read", e, rdata)
  endtask : rd_chk

  task automatic stop_test;
    $display("counts: %0d compared, %0d mismatched", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    seed = 79;
    {rst_b, wr, rd, chk_en, addr, wdata, irq_req, irq_enabled, irq_active} = '0;
    @(posedge clk_sys);
    chk_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst_b       <= 1'b1;
    irq_enabled <= 32'hFFFF_FFFF;
    // Every position is walked; reserved ones get a zero, as software must write there
    for (int k = 0; k < 32; k++) begin
      wr_reg(`PEND_FORCE_OFS, `PEND_IMPL_MASK);
      wr_reg(`PEND_WITHDRAW_OFS, (32'h1 << k) & `PEND_IMPL_MASK);
      rd_chk(`PEND_FORCE_OFS, `PEND_IMPL_MASK & ~(32'h1 << k));
    end
    wr_reg(`PEND_FORCE_OFS, `PEND_IMPL_MASK);
    rd_chk(`PEND_WITHDRAW_OFS, `PEND_IMPL_MASK);
    $display("test withdraw per bit done");
    @(posedge clk_sys);
    irq_active <= 32'h0000_40F0;
    wr_reg(`PEND_WITHDRAW_OFS, 32'h0000_C0FF);
    rd_chk(`PEND_WITHDRAW_OFS, `PEND_IMPL_MASK & ~32'h0000_800F);
    wr_reg(`PEND_WITHDRAW_OFS, 32'h0);
    rd_chk(`PEND_WITHDRAW_OFS, `PEND_IMPL_MASK & ~32'h0000_800F);
    $display("test in service and zero write done");
    wr_reg(`EVT_ENABLE_OFS, 32'h3);
    rd_chk(`EVT_STATUS_OFS, 32'h3);
    `CHK("irq raised", 1'b1, irq)
    wr_reg(`EVT_ENABLE_OFS, 32'h0);
    @(negedge clk_sys);
    `CHK("irq masked", 1'b0, irq)
    wr_reg(`EVT_CLEAR_OFS, 32'h3);
    rd_chk(`EVT_STATUS_OFS, 32'h0);
    rd_chk(8'h14, 32'h0);
    $display("test events done");
    // Random traffic, back to back strobes and unmapped addresses included
    for (int i = 0; i < 600; i++) begin
      @(posedge clk_sys);
      r           = $random(seed);
      wr          <= r[0];
      rd          <= ~r[0] & r[1];
      addr        <= {3'h0, r[4:2], 2'h0};
      wdata       <= $random(seed) & `PEND_IMPL_MASK;
      irq_req     <= $random(seed) & $random(seed) & $random(seed);
      irq_enabled <= $random(seed);
      irq_active  <= $random(seed);
    end
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (2) @(posedge clk_sys);
    $display("test random traffic done");
    stop_test();
  end

endmodule : irq_pend_low_bank_tb
`default_nettype wire
